// ==== rtl/dual_timer_pkg.sv ====
// Package: register map, field layout and mode encodings of the dual-mode timer
package dual_timer_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_COUNT_HIGH    = 8'h01;
	localparam logic [7:0] IDX_RELOAD_HIGH   = 8'h02;
	localparam logic [7:0] IDX_MATCH_HIGH    = 8'h03;
	localparam logic [7:0] IDX_CONTROL       = 8'h08;
	localparam logic [7:0] IDX_STATUS        = 8'h09;
	localparam logic [7:0] IDX_COUNT_VALUE   = 8'h09;
	localparam logic [7:0] IDX_RELOAD_VALUE  = 8'h0a;
	localparam logic [7:0] IDX_MATCH_VALUE   = 8'h0b;
	localparam logic [7:0] IDX_CTRL          = 8'h10;
	localparam logic [7:0] IDX_STAT          = 8'h11;
	localparam logic [7:0] IDX_MODE          = 8'h12;

	localparam int        ADDR_W     = 10;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [15:0] ZERO_HALF = 16'h0000;
	localparam logic [7:0]  ZERO_BYTE = 8'h00;
	localparam logic [15:0] ALL_ONES  = 16'hffff;
	localparam logic [7:0]  BYTE_ONES = 8'hff;
	localparam logic [15:0] ONE_HALF  = 16'h0001;
	localparam logic [7:0]  ONE_BYTE  = 8'h01;

	// Control register field positions
	localparam int CTL_GATE     = 0;
	localparam int CTL_SSHOT    = 1;
	localparam int CTL_RELCAP   = 2;
	localparam int CTL_RUN      = 3;
	localparam int CTL_RUN_LOW  = 4;
	localparam int CTL_POL      = 5;
	localparam int CTL_OE       = 6;
	localparam int CTL_WIDTH    = 8;
	localparam int CTL_CNTSEL   = 9;
	localparam int CTL_EDGE_LO  = 10;
	localparam int CTL_EDGE_HI  = 11;

	// Status register field positions (write one to clear)
	localparam int ST_OVF       = 0;
	localparam int ST_MATCH     = 1;
	localparam int ST_OVF_LOW   = 2;
	localparam int ST_MATCH_LOW = 3;

	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	typedef enum logic [2:0] {
		MODE_RELOAD16,
		MODE_CAPTURE16,
		MODE_COUNTER16,
		MODE_DUAL_RELOAD,
		MODE_DUAL_CAPTURE,
		MODE_DUAL_COUNTER
	} mode_e;

	typedef struct packed {
		logic       oe;
		logic       pol;
		logic       sshot;
		logic       gate;
		logic       relcap;
		logic       run;
		logic       run_low;
		logic       width_mode_bit;
		logic       counter_timer_select;
		logic [1:0] edge_definition_field;
	} ctrl_s;

	typedef struct packed {
		logic [15:0] count_value;
		logic [7:0]  count_high_byte;
		logic [15:0] reload_value;
		logic [7:0]  reload_high_byte;
		logic [15:0] match_capture_value;
		logic [7:0]  match_capture_high_byte;
		ctrl_s       ctrl;
		logic        overflow_flag;
		logic        match_capture_flag;
		logic        overflow_low_flag;
		logic        match_low_flag;
		logic        pin_prev;
		logic        wave;
		logic        ss_armed;
		logic [31:0] readdata;
		logic        rd_done;
		logic        wr_done;
		mode_e       mode;
	} state_s;

endpackage : dual_timer_pkg

// ==== rtl/dual_timer_regs.sv ====
// Module: value, reload and match registers of a 16-bit / dual 8-bit timer
// Notes on behaviour
// - Count value register is 16 bits, fully accessible in sixteen-bit mode.
// - Dual mode: count value reads zero high byte, upper-byte writes dropped.
// - Low counter byte is only the lower byte of count value.
// - Count-high register holds upper counter in dual mode; bits above 7 read zero.
// - Reload value register is 16 bits, fully accessible in sixteen-bit mode.
// - Dual mode: reload value reads zero high byte, upper-byte writes blocked.
// - Low reload byte is only the lower byte of reload value.
// - Reload-high register holds upper reload byte for dual mode.
// - Match register gives compare value; takes counter value on 16-bit capture (match-high takes upper counter in dual).
// - Dual mode: match register reads zero high byte, ignores upper writes.
// - Low match byte is only the lower byte of match register.
// - Match-high register holds upper match byte for dual mode.
// - Six modes chosen by width bit, counter select and edge field.
// - Width 0, select 0, edge 00: 16-bit reload/compare with output options.
// - Width 0, select 0, edge nonzero: 16-bit capture, output disabled.
// - Capture mode: polarity picks gate level or skipped reload edge.
// - Width 0, select 1, edge nonzero: 16-bit counter on chosen edge.
// - Width 1, select 0, edge 00: dual 8-bit reload timers with output.
// - Overflow flag on 16-bit overflow, or upper 8-bit overflow in dual mode.
// - Match flag on compare match or on an external capture edge.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps

module dual_timer_regs (
	input  wire logic                               clk_i,
	input  wire logic                               arst_n_i,
	input  wire logic [dual_timer_pkg::ADDR_W-1:0]  avs_address_i,
	input  wire logic                               avs_read_i,
	input  wire logic                               avs_write_i,
	input  wire logic [31:0]                        avs_writedata_i,
	input  wire logic [3:0]                         avs_byteenable_i,
	output logic      [31:0]                        avs_readdata_o,
	output logic                                    avs_waitrequest_o,
	input  wire logic                               timer_pin_i,
	output logic                                    timer_out_o,
	output logic                                    overflow_flag_o,
	output logic                                    match_capture_flag_o
);

	dual_timer_pkg::state_s st;
	dual_timer_pkg::state_s next_st;
	dual_timer_pkg::mode_e  mode_dec;

	logic [7:0]  idx;
	logic        wr_acc;
	logic        rd_acc;
	logic        dual;
	logic        rise;
	logic        fall;
	logic        cap_edge;
	logic        skip_reload;
	logic        gated;
	logic        tick_hi;
	logic        tick_lo;
	logic        ovf16;
	logic        ovf_hi;
	logic        ovf_lo;
	logic        match16;
	logic        match_hi;
	logic        match_lo;
	logic        set_ovf;
	logic        set_match;
	logic        clr_ok;
	logic [15:0] wmask;
	logic [31:0] rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode; word index is byte address divided by four
	assign idx    = avs_address_i[dual_timer_pkg::ADDR_W-1:2];
	// Reads latch data in the first cycle; writes land at the edge that completes them
	assign wr_acc = avs_write_i && st.wr_done;
	assign rd_acc = avs_read_i && !st.rd_done;
	assign dual   = st.ctrl.width_mode_bit;
	assign wmask  = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

	// Pin is taken as synchronous; edge detect against last sample
	assign rise = timer_pin_i && !st.pin_prev;
	assign fall = !timer_pin_i && st.pin_prev;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode
	// mode from three fields
	always_comb begin
		unique case ({st.ctrl.width_mode_bit, st.ctrl.counter_timer_select,
			st.ctrl.edge_definition_field != dual_timer_pkg::EDGE_NONE})
			3'b000:  mode_dec = dual_timer_pkg::MODE_RELOAD16;
			3'b001:  mode_dec = dual_timer_pkg::MODE_CAPTURE16;
			3'b011:  mode_dec = dual_timer_pkg::MODE_COUNTER16;
			3'b100:  mode_dec = dual_timer_pkg::MODE_DUAL_RELOAD;
			3'b101:  mode_dec = dual_timer_pkg::MODE_DUAL_CAPTURE;
			3'b111:  mode_dec = dual_timer_pkg::MODE_DUAL_COUNTER;
			// Counter select with edge 00 counts nothing; treat as reload timer
			default: mode_dec = dual ? dual_timer_pkg::MODE_DUAL_RELOAD
				: dual_timer_pkg::MODE_RELOAD16;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge and gating terms
	always_comb begin
		// counted or captured edge from edge field
		unique case (st.ctrl.edge_definition_field)
			dual_timer_pkg::EDGE_RISE: cap_edge = rise;
			dual_timer_pkg::EDGE_FALL: cap_edge = fall;
			dual_timer_pkg::EDGE_BOTH: cap_edge = rise || fall;
			default:                   cap_edge = 1'b0;
		endcase
		skip_reload = st.ctrl.gate && st.ctrl.edge_definition_field == dual_timer_pkg::EDGE_BOTH
			&& (st.ctrl.pol ? rise : fall);
		// polarity selects gating level, output must be off
		gated = st.ctrl.gate && !st.ctrl.oe && !st.ctrl.counter_timer_select
			&& st.ctrl.edge_definition_field != dual_timer_pkg::EDGE_BOTH
			&& (timer_pin_i == st.ctrl.pol);
	end

	// Counting ticks: timer modes run on clock, counter modes on the edge
	assign tick_hi = st.ctrl.counter_timer_select ? cap_edge
		: ((st.ctrl.run || st.ss_armed) && !gated);
	// Low byte never gated; only exists in dual mode
	assign tick_lo = dual && st.ctrl.run_low;

	assign ovf16    = !dual && tick_hi && st.count_value == dual_timer_pkg::ALL_ONES;
	assign ovf_hi   = dual && tick_hi && st.count_high_byte == dual_timer_pkg::BYTE_ONES;
	assign ovf_lo   = tick_lo && st.count_value[7:0] == dual_timer_pkg::BYTE_ONES;
	// 16-bit and upper-byte compare only in reload/compare modes; low byte compares in every dual mode
	assign match16  = !dual && st.ctrl.edge_definition_field == dual_timer_pkg::EDGE_NONE
		&& tick_hi && st.count_value == st.match_capture_value;
	assign match_hi = dual && st.ctrl.edge_definition_field == dual_timer_pkg::EDGE_NONE
		&& tick_hi && st.count_high_byte == st.match_capture_high_byte;
	assign match_lo = tick_lo && st.count_value[7:0] == st.match_capture_value[7:0];

	assign set_ovf   = ovf16 || ovf_hi;
	assign set_match = match16 || match_hi
		|| (!st.ctrl.counter_timer_select && st.ctrl.edge_definition_field
			!= dual_timer_pkg::EDGE_NONE && cap_edge);
	// Flag clear request, taken at the completing edge of a status write
	assign clr_ok    = wr_acc && idx == dual_timer_pkg::IDX_STAT && avs_byteenable_i[0];

	////////////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses read zero
	always_comb begin
		rdata = dual_timer_pkg::ZERO_WORD;
		unique case (idx)
			// high byte hidden in dual mode
			dual_timer_pkg::IDX_COUNT_VALUE:
				rdata[15:0] = {dual ? dual_timer_pkg::ZERO_BYTE : st.count_value[15:8],
					st.count_value[7:0]};
			dual_timer_pkg::IDX_RELOAD_VALUE:
				rdata[15:0] = {dual ? dual_timer_pkg::ZERO_BYTE : st.reload_value[15:8],
					st.reload_value[7:0]};
			dual_timer_pkg::IDX_MATCH_VALUE:
				rdata[15:0] = {dual ? dual_timer_pkg::ZERO_BYTE : st.match_capture_value[15:8],
					st.match_capture_value[7:0]};
			dual_timer_pkg::IDX_COUNT_HIGH:  rdata[7:0] = st.count_high_byte;
			dual_timer_pkg::IDX_RELOAD_HIGH: rdata[7:0] = st.reload_high_byte;
			dual_timer_pkg::IDX_MATCH_HIGH:  rdata[7:0] = st.match_capture_high_byte;
			dual_timer_pkg::IDX_CTRL: begin
				rdata[dual_timer_pkg::CTL_GATE]    = st.ctrl.gate;
				rdata[dual_timer_pkg::CTL_SSHOT]   = st.ss_armed;
				rdata[dual_timer_pkg::CTL_RELCAP]  = st.ctrl.relcap;
				rdata[dual_timer_pkg::CTL_RUN]     = st.ctrl.run;
				rdata[dual_timer_pkg::CTL_RUN_LOW] = st.ctrl.run_low;
				rdata[dual_timer_pkg::CTL_POL]     = st.ctrl.pol;
				rdata[dual_timer_pkg::CTL_OE]      = st.ctrl.oe;
				rdata[dual_timer_pkg::CTL_WIDTH]   = st.ctrl.width_mode_bit;
				rdata[dual_timer_pkg::CTL_CNTSEL]  = st.ctrl.counter_timer_select;
				rdata[dual_timer_pkg::CTL_EDGE_HI:dual_timer_pkg::CTL_EDGE_LO] =
					st.ctrl.edge_definition_field;
			end
			dual_timer_pkg::IDX_STAT: begin
				rdata[dual_timer_pkg::ST_OVF]       = st.overflow_flag;
				rdata[dual_timer_pkg::ST_MATCH]     = st.match_capture_flag;
				rdata[dual_timer_pkg::ST_OVF_LOW]   = st.overflow_low_flag;
				rdata[dual_timer_pkg::ST_MATCH_LOW] = st.match_low_flag;
			end
			dual_timer_pkg::IDX_MODE: rdata[2:0] = st.mode;
			default: rdata = dual_timer_pkg::ZERO_WORD;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state: counting first, then software writes override
	always_comb begin
		next_st.count_value             = st.count_value;
		next_st.count_high_byte         = st.count_high_byte;
		next_st.reload_value            = st.reload_value;
		next_st.reload_high_byte        = st.reload_high_byte;
		next_st.match_capture_value     = st.match_capture_value;
		next_st.match_capture_high_byte = st.match_capture_high_byte;
		next_st.ctrl                    = st.ctrl;
		next_st.pin_prev                = timer_pin_i;
		next_st.wave                    = st.wave;
		next_st.ss_armed                = st.ss_armed;
		next_st.mode                    = mode_dec;
		next_st.wr_done                 = avs_write_i && !st.wr_done;
		next_st.rd_done                 = rd_acc;
		next_st.readdata                = rd_acc ? rdata : st.readdata;

		// 16-bit count with reload on overflow
		if (!dual && tick_hi) begin
			next_st.count_value = ovf16 ? st.reload_value
				: st.count_value + dual_timer_pkg::ONE_HALF;
		end
		// low byte counts in place in dual mode
		if (tick_lo) begin
			next_st.count_value[7:0] = ovf_lo ? st.reload_value[7:0]
				: st.count_value[7:0] + dual_timer_pkg::ONE_BYTE;
		end
		if (dual && tick_hi) begin
			next_st.count_high_byte = ovf_hi ? st.reload_high_byte
				: st.count_high_byte + dual_timer_pkg::ONE_BYTE;
		end
		// Output toggles on match or overflow; single toggle when both coincide
		if ((set_ovf || match16 || match_hi) && st.ctrl.edge_definition_field
			== dual_timer_pkg::EDGE_NONE) begin
			next_st.wave = !st.wave;
		end
		// Single shot ends at overflow/reload
		if (set_ovf) begin
			next_st.ss_armed = 1'b0;
		end
		if (!st.ctrl.counter_timer_select && cap_edge) begin
			if (dual) begin
				next_st.match_capture_high_byte = st.count_high_byte;
			end else begin
				next_st.match_capture_value = st.count_value;
			end
			if (st.ctrl.relcap && !skip_reload) begin
				if (dual) begin
					next_st.count_high_byte = st.reload_high_byte;
				end else begin
					next_st.count_value = st.reload_value;
				end
			end
		end

		if (wr_acc) begin
			unique case (idx)
				// upper byte writes dropped in dual mode
				dual_timer_pkg::IDX_COUNT_VALUE:
					next_st.count_value = (next_st.count_value & ~(wmask & {dual ? 8'h00 : 8'hff, 8'hff}))
						| (avs_writedata_i[15:0] & wmask & {dual ? 8'h00 : 8'hff, 8'hff});
				// reload upper byte blocked in dual mode
				dual_timer_pkg::IDX_RELOAD_VALUE:
					next_st.reload_value = (st.reload_value & ~(wmask & {dual ? 8'h00 : 8'hff, 8'hff}))
						| (avs_writedata_i[15:0] & wmask & {dual ? 8'h00 : 8'hff, 8'hff});
				// match upper byte writes ignored in dual mode
				dual_timer_pkg::IDX_MATCH_VALUE:
					next_st.match_capture_value =
						(next_st.match_capture_value & ~(wmask & {dual ? 8'h00 : 8'hff, 8'hff}))
						| (avs_writedata_i[15:0] & wmask & {dual ? 8'h00 : 8'hff, 8'hff});
				dual_timer_pkg::IDX_COUNT_HIGH:
					if (avs_byteenable_i[0]) next_st.count_high_byte = avs_writedata_i[7:0];
				dual_timer_pkg::IDX_RELOAD_HIGH:
					if (avs_byteenable_i[0]) next_st.reload_high_byte = avs_writedata_i[7:0];
				dual_timer_pkg::IDX_MATCH_HIGH:
					if (avs_byteenable_i[0]) next_st.match_capture_high_byte = avs_writedata_i[7:0];
				dual_timer_pkg::IDX_CTRL: begin
					if (avs_byteenable_i[0]) begin
						next_st.ctrl.gate    = avs_writedata_i[dual_timer_pkg::CTL_GATE];
						next_st.ctrl.relcap  = avs_writedata_i[dual_timer_pkg::CTL_RELCAP];
						next_st.ctrl.run     = avs_writedata_i[dual_timer_pkg::CTL_RUN];
						next_st.ctrl.run_low = avs_writedata_i[dual_timer_pkg::CTL_RUN_LOW];
						next_st.ctrl.pol     = avs_writedata_i[dual_timer_pkg::CTL_POL];
						next_st.ctrl.oe      = avs_writedata_i[dual_timer_pkg::CTL_OE];
						if (avs_writedata_i[dual_timer_pkg::CTL_SSHOT]) next_st.ss_armed = 1'b1;
						// Polarity sets the start level when output is enabled
						if (avs_writedata_i[dual_timer_pkg::CTL_OE] && !st.ctrl.oe) begin
							next_st.wave = 1'b0;
						end
					end
					if (avs_byteenable_i[1]) begin
						next_st.ctrl.width_mode_bit = avs_writedata_i[dual_timer_pkg::CTL_WIDTH];
						next_st.ctrl.counter_timer_select =
							avs_writedata_i[dual_timer_pkg::CTL_CNTSEL];
						next_st.ctrl.edge_definition_field =
							avs_writedata_i[dual_timer_pkg::CTL_EDGE_HI:dual_timer_pkg::CTL_EDGE_LO];
					end
				end
				default: ;
			endcase
		end
		// Status flags: hardware set wins over write-one-to-clear
		// overflow flag
		next_st.overflow_flag = set_ovf || (st.overflow_flag
			&& !(clr_ok && avs_writedata_i[dual_timer_pkg::ST_OVF]));
		next_st.match_capture_flag = set_match || (st.match_capture_flag
			&& !(clr_ok && avs_writedata_i[dual_timer_pkg::ST_MATCH]));
		next_st.overflow_low_flag = ovf_lo || (st.overflow_low_flag
			&& !(clr_ok && avs_writedata_i[dual_timer_pkg::ST_OVF_LOW]));
		next_st.match_low_flag = match_lo || (st.match_low_flag
			&& !(clr_ok && avs_writedata_i[dual_timer_pkg::ST_MATCH_LOW]));
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register
	// everything clears on reset
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Readdata and flags straight from flops; waitrequest and timer output decoded
	assign avs_readdata_o       = st.readdata;
	assign avs_waitrequest_o    = !((avs_read_i && st.rd_done) || (avs_write_i && st.wr_done));
	assign overflow_flag_o      = st.overflow_flag;
	assign match_capture_flag_o = st.match_capture_flag;
	// output only in 16-bit or dual reload modes with counter select clear
	assign timer_out_o = st.ctrl.oe && st.ctrl.edge_definition_field == dual_timer_pkg::EDGE_NONE
		&& !st.ctrl.counter_timer_select && (st.wave ^ st.ctrl.pol);

endmodule : dual_timer_regs

// ==== bench/dual_timer_regs_checker.sv ====
// Checker: port-level assertions for the dual-mode timer register block
`timescale 1ns/100ps

module dual_timer_regs_checker (
	input wire logic                              clk_i,
	input wire logic                              arst_n_i,
	input wire logic [dual_timer_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic                              avs_read_i,
	input wire logic                              avs_write_i,
	input wire logic [31:0]                       avs_writedata_i,
	input wire logic [3:0]                        avs_byteenable_i,
	input wire logic [31:0]                       avs_readdata_o,
	input wire logic                              avs_waitrequest_o,
	input wire logic                              timer_pin_i,
	input wire logic                              timer_out_o,
	input wire logic                              overflow_flag_o,
	input wire logic                              match_capture_flag_o
);
	logic       dual_q;
	logic [1:0] edge_q;
	logic [7:0] idx;
	logic       rd_ok;

	assign idx = avs_address_i[9:2];
	assign rd_ok = avs_read_i && !avs_waitrequest_o;

	// Shadow of mode bits; updated at completion, the same edge at which the design takes the write
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dual_q <= 1'b0;
			edge_q <= 2'h0;
		end else if (avs_write_i && !avs_waitrequest_o && idx == 8'h10 && avs_byteenable_i[1]) begin
			dual_q <= avs_writedata_i[8];
			edge_q <= avs_writedata_i[11:10];
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_wait_idle: assert property (!avs_read_i && !avs_write_i |-> avs_waitrequest_o)
		else $error("waitrequest low while idle");
	a_one_wait: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
		else $error("answer not in second cycle");
	a_ovf_sticky: assert property ($fell(overflow_flag_o) |-> $past(avs_write_i && idx == 8'h11 && avs_writedata_i[0]))
		else $error("overflow flag dropped without clear");
	a_match_sticky: assert property ($fell(match_capture_flag_o) |-> $past(avs_write_i && idx == 8'h11 && avs_writedata_i[1]))
		else $error("match flag dropped without clear");
	a_count_hide: assert property (rd_ok && dual_q && idx == 8'h09 |-> avs_readdata_o[15:8] == 8'h00)
		else $error("count high byte visible in dual mode");
	a_reload_hide: assert property (rd_ok && dual_q && idx == 8'h0a |-> avs_readdata_o[15:8] == 8'h00)
		else $error("reload high byte visible in dual mode");
	a_match_hide: assert property (rd_ok && dual_q && idx == 8'h0b |-> avs_readdata_o[15:8] == 8'h00)
		else $error("match high byte visible in dual mode");
	a_high_reserved: assert property (rd_ok && idx inside {8'h01, 8'h02, 8'h03} |-> avs_readdata_o[31:8] == 24'h0)
		else $error("reserved high bits not zero");
	a_unmapped_zero: assert property (rd_ok && idx > 8'h12 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	a_out_off: assert property (edge_q != 2'h0 && $past(edge_q) != 2'h0 |-> !timer_out_o)
		else $error("output driven in edge mode");
endmodule : dual_timer_regs_checker

bind dual_timer_regs dual_timer_regs_checker i_dual_timer_regs_checker (
	.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
	.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .timer_pin_i(timer_pin_i), .timer_out_o(timer_out_o),
	.overflow_flag_o(overflow_flag_o), .match_capture_flag_o(match_capture_flag_o));

// ==== bench/dual_timer_regs_test.sv ====
// Testbench: register access, mode decode and flags of the dual-mode timer
`timescale 1ns/100ps

module dual_timer_regs_test;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [9:0]  avs_address_i = 10'h000;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'h0;
	logic        timer_pin_i = 1'b0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        timer_out_o;
	logic        overflow_flag_o;
	logic        match_capture_flag_o;
	logic [31:0] rdata;
	int          fail_count = 0;
	int          n_compared = 0;
	int          cycles = 0;

	dual_timer_regs i_dual_timer_regs (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .timer_pin_i(timer_pin_i), .timer_out_o(timer_out_o),
		.overflow_flag_o(overflow_flag_o), .match_capture_flag_o(match_capture_flag_o));

	always #2 clk_i = ~clk_i;

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task results();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : results

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
			fail_count++;
		end
	endtask : check

	// One Avalon access; request held until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= {idx, 2'b00};
		avs_writedata_i <= wd;
		avs_byteenable_i <= 4'h3;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		@(posedge clk_i);
		while (avs_waitrequest_o !== 1'b0 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (n == 20)
			check("waitrequest", {31'h0, avs_waitrequest_o}, 32'h0);
		rdata = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		// The write lands at the completing edge; one more edge lets callers see it
		@(posedge clk_i);
	endtask : bus

	task rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
		bus(1'b0, idx, 32'h0);
		check(name, rdata, exp);
	endtask : rdchk

	// Wait, bounded, for a flag to rise: sel 0 overflow, 1 match
	task flag_wait(input logic sel);
		int n;
		for (n = 0; n < 100 && (sel ? match_capture_flag_o : overflow_flag_o) !== 1'b1; n++)
			@(posedge clk_i);
		check(sel ? "match_flag" : "overflow_flag", {31'h0, sel ? match_capture_flag_o : overflow_flag_o}, 32'h1);
	endtask : flag_wait

	function automatic logic [2:0] mode_of(logic w, logic c, logic [1:0] e);
		if (e == 2'h0)
			return w ? 3'h3 : 3'h0;
		return w ? (c ? 3'h5 : 3'h4) : (c ? 3'h2 : 3'h1);
	endfunction : mode_of

	////////////////////////////////////////////////////////////////////////////////
	task t_reset();
		logic [7:0] idx [7] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h0b, 8'h20};
		check("flags_reset", {30'h0, overflow_flag_o, match_capture_flag_o}, 32'h0);
		foreach (idx[i])
			rdchk("reset_value", idx[i], 32'h0);
		$display("test reset done");
	endtask : t_reset

	// Every width/select/edge combination, output enabled with high polarity
	task t_modes();
		logic [2:0] m;
		for (int k = 0; k < 16; k++) begin
			m = mode_of(k[3], k[2], k[1:0]);
			bus(1'b1, 8'h10, {20'h0, k[1:0], k[2], k[3], 8'h60});
			rdchk("mode", 8'h12, {29'h0, m});
			// Output only with counter select clear and edge field 00
			check("timer_out", {31'h0, timer_out_o}, {31'h0, k[1:0] == 2'h0 && !k[2]});
		end
		bus(1'b1, 8'h10, 32'h0);
		$display("test modes done");
	endtask : t_modes

	task t_wide();
		logic [31:0] val [3] = '{32'ha5c3, 32'h5a3c, 32'h1234};
		for (int i = 0; i < 3; i++)
			bus(1'b1, 8'h09 + i[7:0], val[i]);
		for (int i = 0; i < 3; i++)
			rdchk("wide_value", 8'h09 + i[7:0], val[i]);
		$display("test wide done");
	endtask : t_wide

	task t_dual();
		bus(1'b1, 8'h10, 32'h0100);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, 8'h09 + i[7:0], 32'hbb77);
			rdchk("dual_value", 8'h09 + i[7:0], 32'h0077);
			bus(1'b1, 8'h01 + i[7:0], 32'hff5a);
			rdchk("high_byte", 8'h01 + i[7:0], 32'h005a);
		end
		bus(1'b1, 8'h10, 32'h0);
		$display("test dual done");
	endtask : t_dual

	task t_flags();
		bus(1'b1, 8'h11, 32'hf);
		check("flags_clear", {30'h0, overflow_flag_o, match_capture_flag_o}, 32'h0);
		bus(1'b1, 8'h0a, 32'h0);
		bus(1'b1, 8'h0b, 32'h0008);
		bus(1'b1, 8'h09, 32'hfff8);
		bus(1'b1, 8'h10, 32'h0008);
		flag_wait(1'b0);
		flag_wait(1'b1);
		bus(1'b1, 8'h10, 32'h0100);
		bus(1'b1, 8'h11, 32'hf);
		check("flags_w1c", {30'h0, overflow_flag_o, match_capture_flag_o}, 32'h0);
		bus(1'b1, 8'h01, 32'h00fd);
		bus(1'b1, 8'h10, 32'h0108);
		flag_wait(1'b0);
		bus(1'b1, 8'h10, 32'h0);
		$display("test flags done");
	endtask : t_flags

	// Rising-edge capture while counting from zero
	task t_capture();
		bus(1'b1, 8'h11, 32'hf);
		bus(1'b1, 8'h09, 32'h0);
		bus(1'b1, 8'h10, 32'h0408);
		repeat (20) @(posedge clk_i);
		timer_pin_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		bus(1'b1, 8'h10, 32'h0400);
		bus(1'b0, 8'h0b, 32'h0);
		check("capture_range", {31'h0, rdata >= 32'h10 && rdata <= 32'h40}, 32'h1);
		check("capture_flag", {31'h0, match_capture_flag_o}, 32'h1);
		timer_pin_i <= 1'b0;
		$display("test capture done");
	endtask : t_capture

	initial begin
		repeat (10) @(posedge clk_i);
		arst_n_i <= 1'b1;
		t_reset();
		t_modes();
		t_wide();
		t_dual();
		t_flags();
		t_capture();
		results();
	end
endmodule : dual_timer_regs_test
